// ---- design/tccp_timer.sv ----
// timer/counter with capture, compare and pwm channels and dead-time
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - counter is 16 or 32 bits wide, fixed per instance.
// - three channels, each off or in capture, compare or pwm mode.
// - capture copies counter into channel value register ccv on selected input edge.
// - compare mode drives channel output from counter versus threshold match.
// - pwm output follows successive compare values, reloaded at period wrap.
// - optional dead-time gap between complementary pwm transitions.
// - wrap and channel events pulse trigger lines into the event network.
// - counter counts clock ticks or external event pulses.
module tccp_timer #(
    parameter bit WIDE32 = 1'b1,
    parameter bit HAS_DTI = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [tccp_pkg::TCCP_AW-1:0] addr,
    input wire logic [tccp_pkg::TCCP_DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [tccp_pkg::TCCP_DW-1:0] rdata,
    input wire logic cnt_evt_in,
    input wire logic [tccp_pkg::TCCP_NCH-1:0] cap_in,
    output logic [tccp_pkg::TCCP_NCH-1:0] cc_out_p,
    output logic [tccp_pkg::TCCP_NCH-1:0] cc_out_n,
    output logic [tccp_pkg::TCCP_NEV-1:0] peripheral_event_network,
    output logic irq
);
    import tccp_pkg::*;

    typedef struct packed {
        logic en;
        logic evsrc;
        logic [31:0] top;
        logic [31:0] cnt;
        logic [TCCP_NEV-1:0] sts;
        logic [TCCP_NEV-1:0] ien;
        logic dt_en;
        logic [TCCP_DT_LEN_W-1:0] dt_len;
        logic [TCCP_NCH-1:0][TCCP_CFG_W-1:0] cfg;
        logic [TCCP_NCH-1:0][31:0] ccv;
        logic [TCCP_NCH-1:0][31:0] ccb;
        logic [TCCP_NCH-1:0] out;
        logic [TCCP_NCH-1:0] cap_q;
        logic [TCCP_NEV-1:0] ev;
        logic [31:0] rdata;
    } tccp_state_t;

    tccp_state_t st_ff;
    tccp_state_t nxt_st;
    logic [31:0] cnt_mask;
    logic [31:0] top_eff;
    logic tick;
    logic wrap;

    // ------------------------------------------------------------
    // counter width and tick source
    // ------------------------------------------------------------
    // width fixed per instance
    assign cnt_mask = WIDE32 ? '1 : TCCP_MASK16;
    assign top_eff = st_ff.top & cnt_mask;
    assign tick = st_ff.en && (st_ff.evsrc ? cnt_evt_in : 1'b1);
    assign wrap = tick && (st_ff.cnt == top_eff);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] ch_base;
        tccp_mode_t mode;
        tccp_act_t act;
        logic rise;
        logic fall;
        logic hit;
        logic match;
        ch_base = '0;
        mode = TCCP_MODE_OFF;
        act = TCCP_ACT_NONE;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        match = 1'b0;
        nxt_st = st_ff;
        nxt_st.ev = '0;
        nxt_st.rdata = '0;

        // register reads, data one cycle later
        if (rd_en) begin
            unique case (addr)
                TCCP_OFS_CTRL: begin
                    nxt_st.rdata[TCCP_CTRL_EN] = st_ff.en;
                    nxt_st.rdata[TCCP_CTRL_EVSRC] = st_ff.evsrc;
                end
                TCCP_OFS_TOP: nxt_st.rdata = top_eff;
                TCCP_OFS_CNT: nxt_st.rdata = st_ff.cnt;
                TCCP_OFS_STS: begin
                    nxt_st.rdata[TCCP_NEV-1:0] = st_ff.sts;
                    nxt_st.sts = '0;
                end
                TCCP_OFS_IEN: nxt_st.rdata[TCCP_NEV-1:0] = st_ff.ien;
                TCCP_OFS_DT: begin
                    nxt_st.rdata[TCCP_DT_LEN +: TCCP_DT_LEN_W] = st_ff.dt_len;
                    nxt_st.rdata[TCCP_DT_EN] = st_ff.dt_en;
                end
                default: begin
                    for (int i = 0; i < TCCP_NCH; i++) begin
                        ch_base = TCCP_OFS_CH_BASE + 8'(i) * TCCP_OFS_CH_STRIDE;
                        if (addr == ch_base + TCCP_OFS_CH_CFG) begin
                            nxt_st.rdata[TCCP_CFG_W-1:0] = st_ff.cfg[i];
                        end
                        if (addr == ch_base + TCCP_OFS_CH_CCV) begin
                            nxt_st.rdata = st_ff.ccv[i];
                        end
                    end
                end
            endcase
        end

        // register writes
        if (wr_en) begin
            unique case (addr)
                TCCP_OFS_CTRL: begin
                    nxt_st.en = wdata[TCCP_CTRL_EN];
                    nxt_st.evsrc = wdata[TCCP_CTRL_EVSRC];
                end
                TCCP_OFS_TOP: nxt_st.top = wdata & cnt_mask;
                TCCP_OFS_CNT: nxt_st.cnt = wdata & cnt_mask;
                TCCP_OFS_IEN: nxt_st.ien = wdata[TCCP_NEV-1:0];
                TCCP_OFS_DT: begin
                    nxt_st.dt_len = wdata[TCCP_DT_LEN +: TCCP_DT_LEN_W];
                    nxt_st.dt_en = wdata[TCCP_DT_EN] & HAS_DTI;
                end
                default: begin
                    for (int i = 0; i < TCCP_NCH; i++) begin
                        ch_base = TCCP_OFS_CH_BASE + 8'(i) * TCCP_OFS_CH_STRIDE;
                        if (addr == ch_base + TCCP_OFS_CH_CFG) begin
                            nxt_st.cfg[i] = wdata[TCCP_CFG_W-1:0];
                        end
                        if (addr == ch_base + TCCP_OFS_CH_CCV) begin
                            nxt_st.ccb[i] = wdata & cnt_mask;
                            if (tccp_mode_t'(st_ff.cfg[i][TCCP_CFG_MODE +: 2])
                                    != TCCP_MODE_PWM) begin
                                nxt_st.ccv[i] = wdata & cnt_mask;
                            end
                        end
                    end
                end
            endcase
        end

        if (tick && !(wr_en && addr == TCCP_OFS_CNT)) begin
            nxt_st.cnt = wrap ? '0 : (st_ff.cnt + 32'h1) & cnt_mask;
        end
        if (wrap) begin
            nxt_st.ev[TCCP_STS_WRAP] = 1'b1;
        end

        for (int i = 0; i < TCCP_NCH; i++) begin
            mode = tccp_mode_t'(st_ff.cfg[i][TCCP_CFG_MODE +: 2]);
            act = tccp_act_t'(st_ff.cfg[i][TCCP_CFG_ACT +: 2]);
            rise = cap_in[i] && !st_ff.cap_q[i];
            fall = !cap_in[i] && st_ff.cap_q[i];
            hit = (st_ff.cfg[i][TCCP_CFG_EDGE +: 2] & {fall, rise}) != 2'b00;
            match = tick && (st_ff.cnt == st_ff.ccv[i]);
            nxt_st.cap_q[i] = cap_in[i];
            unique case (mode)
                TCCP_MODE_OFF: nxt_st.out[i] = 1'b0;
                TCCP_MODE_CAP: begin
                    if (hit) begin
                        nxt_st.ccv[i] = st_ff.cnt;
                        nxt_st.ev[i+1] = 1'b1;
                    end
                end
                TCCP_MODE_CMP: begin
                    if (match) begin
                        nxt_st.ev[i+1] = 1'b1;
                        unique case (act)
                            TCCP_ACT_NONE: nxt_st.out[i] = st_ff.out[i];
                            TCCP_ACT_SET: nxt_st.out[i] = 1'b1;
                            TCCP_ACT_CLR: nxt_st.out[i] = 1'b0;
                            TCCP_ACT_TGL: nxt_st.out[i] = !st_ff.out[i];
                        endcase
                    end
                end
                TCCP_MODE_PWM: begin
                    if (wrap) begin
                        nxt_st.ccv[i] = st_ff.ccb[i];
                    end
                    if (match) begin
                        nxt_st.ev[i+1] = 1'b1;
                    end
                    nxt_st.out[i] = nxt_st.cnt < nxt_st.ccv[i];
                end
            endcase
        end

        // status set wins over read clear
        nxt_st.sts = nxt_st.sts | nxt_st.ev;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.top <= TCCP_RST_TOP;
            st_ff.dt_len <= TCCP_RST_DT_LEN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign irq = |(st_ff.sts & st_ff.ien);
    assign peripheral_event_network = st_ff.ev;

    // ------------------------------------------------------------
    // dead-time per channel
    // ------------------------------------------------------------
    // complementary pair with gap
    for (genvar g = 0; g < TCCP_NCH; g++) begin : g_dt
        tccp_deadtime u_dt (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .dt_en(st_ff.dt_en),
            .dt_len(st_ff.dt_len),
            .pwm_in(st_ff.out[g]),
            .out_p(cc_out_p[g]),
            .out_n(cc_out_n[g])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_wrap_tick;
        tick && (st_ff.cnt == top_eff) && !wr_en;
    endsequence

    a_wrap_to_zero:
    assert property (s_wrap_tick |=> st_ff.cnt == '0 ##0 peripheral_event_network[0])
        else $error("counter did not wrap to zero");

    a_cnt_step_one:
    assert property (tick && !wr_en && st_ff.cnt != top_eff
        |=> st_ff.cnt == (($past(st_ff.cnt) + 32'h1) & cnt_mask))
        else $error("counter did not step by one");

    a_cnt_idle_hold:
    assert property (st_ff.en && st_ff.evsrc && !cnt_evt_in && !wr_en
        |=> $stable(st_ff.cnt))
        else $error("counter moved without event");

    a_width_16bit:
    assert property (!WIDE32 |-> (st_ff.cnt & ~TCCP_MASK16) == '0)
        else $error("narrow counter uses upper bits");

    a_cap_copy_cnt:
    assert property (st_ff.cfg[0][1:0] == 2'(TCCP_MODE_CAP) && cap_in[0] && !st_ff.cap_q[0]
        && st_ff.cfg[0][TCCP_CFG_EDGE] |=> st_ff.ccv[0] == $past(st_ff.cnt))
        else $error("capture missed counter value");

    a_cmp_set_out:
    assert property (st_ff.cfg[1] == {2'(TCCP_ACT_SET), 2'b00, 2'(TCCP_MODE_CMP)}
        && tick && st_ff.cnt == st_ff.ccv[1] && !wr_en |=> st_ff.out[1])
        else $error("compare match did not set output");

    a_pwm_duty_lvl:
    assert property (st_ff.cfg[2][1:0] == 2'(TCCP_MODE_PWM) && $past(st_ff.cfg[2][1:0])
        == 2'(TCCP_MODE_PWM) |-> st_ff.out[2] == (st_ff.cnt < st_ff.ccv[2]))
        else $error("pwm level disagrees with counter");

    a_pwm_reload_buf:
    assert property (s_wrap_tick ##0 st_ff.cfg[2][1:0] == 2'(TCCP_MODE_PWM)
        |=> st_ff.ccv[2] == $past(st_ff.ccb[2]))
        else $error("pwm threshold not reloaded at wrap");

    a_cap_out_hold:
    assert property (st_ff.cfg[0][1:0] == 2'(TCCP_MODE_CAP) && !wr_en
        |=> $stable(st_ff.out[0]))
        else $error("capture channel moved its output");

    a_sts_read_set:
    assert property (rd_en && addr == TCCP_OFS_STS && wrap |=> st_ff.sts[0])
        else $error("wrap event lost under status read");
endmodule : tccp_timer
`default_nettype wire

// ---- design/tccp_pkg.sv ----
// shared constants and types of the timer with capture, compare and pwm channels
package tccp_pkg;
    localparam int TCCP_NCH = 3;
    localparam int TCCP_AW = 8;
    localparam int TCCP_DW = 32;
    localparam int TCCP_NEV = TCCP_NCH + 1;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TCCP_OFS_CTRL = 8'h00;
    localparam logic [7:0] TCCP_OFS_TOP = 8'h04;
    localparam logic [7:0] TCCP_OFS_CNT = 8'h08;
    localparam logic [7:0] TCCP_OFS_STS = 8'h0c;
    localparam logic [7:0] TCCP_OFS_IEN = 8'h10;
    localparam logic [7:0] TCCP_OFS_DT = 8'h14;
    localparam logic [7:0] TCCP_OFS_CH_BASE = 8'h20;
    localparam logic [7:0] TCCP_OFS_CH_STRIDE = 8'h10;
    localparam logic [7:0] TCCP_OFS_CH_CFG = 8'h00;
    localparam logic [7:0] TCCP_OFS_CH_CCV = 8'h04;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TCCP_CTRL_EN = 0;
    localparam int TCCP_CTRL_EVSRC = 1;
    localparam int TCCP_CFG_MODE = 0;
    localparam int TCCP_CFG_EDGE = 2;
    localparam int TCCP_CFG_ACT = 4;
    localparam int TCCP_CFG_W = 6;
    localparam int TCCP_DT_LEN = 0;
    localparam int TCCP_DT_LEN_W = 8;
    localparam int TCCP_DT_EN = 8;
    localparam int TCCP_STS_WRAP = 0;
    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam logic [31:0] TCCP_RST_TOP = 32'hffffffff;
    localparam logic [31:0] TCCP_MASK16 = 32'h0000ffff;
    localparam logic [7:0] TCCP_RST_DT_LEN = 8'h00;
    typedef enum logic [1:0] {
        TCCP_MODE_OFF,
        TCCP_MODE_CAP,
        TCCP_MODE_CMP,
        TCCP_MODE_PWM
    } tccp_mode_t;
    typedef enum logic [1:0] {
        TCCP_ACT_NONE,
        TCCP_ACT_SET,
        TCCP_ACT_CLR,
        TCCP_ACT_TGL
    } tccp_act_t;
endpackage : tccp_pkg

// ---- design/tccp_deadtime.sv ----
// dead-time gap between the complementary pair of one pwm channel
`timescale 1ns/1ps
`default_nettype none
module tccp_deadtime (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic dt_en,
    input wire logic [tccp_pkg::TCCP_DT_LEN_W-1:0] dt_len,
    input wire logic pwm_in,
    output logic out_p,
    output logic out_n
);
    import tccp_pkg::*;

    typedef struct packed {
        logic lvl;
        logic [TCCP_DT_LEN_W-1:0] gap;
        logic p;
        logic n;
    } tccp_dt_state_t;

    tccp_dt_state_t st_ff;
    tccp_dt_state_t nxt_st;

    // ------------------------------------------------------------
    // gap counter
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lvl = pwm_in;
        if (!dt_en) begin
            nxt_st.gap = '0;
            nxt_st.p = pwm_in;
            nxt_st.n = ~pwm_in;
        end else if (pwm_in != st_ff.lvl) begin
            nxt_st.gap = dt_len;
            nxt_st.p = 1'b0;
            nxt_st.n = 1'b0;
        end else if (st_ff.gap != '0) begin
            nxt_st.gap = st_ff.gap - 1'b1;
        end else begin
            nxt_st.p = st_ff.lvl;
            nxt_st.n = ~st_ff.lvl;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign out_p = st_ff.p;
    assign out_n = st_ff.n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_edge_gap;
        dt_en && (pwm_in != st_ff.lvl) && (dt_len != '0);
    endsequence

    a_dt_gap_low:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_edge_gap ##1 dt_en |=> !out_p && !out_n)
        else $error("pair not both off after edge");

    a_dt_no_overlap:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(out_p && out_n))
        else $error("complementary outputs overlap");
endmodule : tccp_deadtime
`default_nettype wire

// ---- tb/tccp_evt_partner.sv ----
// far-side model: event-network consumer and capture signal source
`timescale 1ns/1ps
`default_nettype none
module tccp_evt_partner (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [tccp_pkg::TCCP_NEV-1:0] evt,
    input wire logic [tccp_pkg::TCCP_NCH-1:0] cap_go,
    output logic [tccp_pkg::TCCP_NCH-1:0] cap_src,
    output logic [tccp_pkg::TCCP_NEV-1:0][15:0] evt_cnt
);
    import tccp_pkg::*;
    // ------------------------------------------------------------
    // capture sources follow the bench, triggers are tallied
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cap_src <= 3'h0;
            evt_cnt <= {TCCP_NEV{16'h0000}};
        end else begin
            cap_src <= cap_go;
            for (int i = 0; i < TCCP_NEV; i++) begin
                evt_cnt[i] <= evt_cnt[i] + 16'(evt[i]);
            end
        end
    end
endmodule : tccp_evt_partner
`default_nettype wire

// ---- tb/tccp_timer_tb.sv ----
// self-checking bench of the timer with capture, compare and pwm channels
`timescale 1ns/1ps
`default_nettype none
module tccp_timer_tb;
    import tccp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [TCCP_AW-1:0] addr = 8'h00;
    logic [TCCP_DW-1:0] wdata = 32'h00000000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [TCCP_DW-1:0] rdata, rdata16;
    logic cnt_evt_in = 1'b0;
    logic [TCCP_NCH-1:0] cap_in, cc_out_p, cc_out_n;
    logic [TCCP_NCH-1:0] cap_go = 3'h0;
    logic [TCCP_NEV-1:0] pen;
    logic [TCCP_NEV-1:0][15:0] evt_cnt;
    logic irq;
    int err_total = 0;
    int compares = 0;
    always #4 clk_sys = ~clk_sys;
    tccp_timer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cnt_evt_in(cnt_evt_in),
        .cap_in(cap_in), .cc_out_p(cc_out_p), .cc_out_n(cc_out_n),
        .peripheral_event_network(pen), .irq(irq));
    tccp_timer #(.WIDE32(1'b0), .HAS_DTI(1'b0)) i_dut16 (.clk_sys(clk_sys), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata16),
        .cnt_evt_in(cnt_evt_in), .cap_in(cap_in), .cc_out_p(), .cc_out_n(),
        .peripheral_event_network(), .irq());
    tccp_evt_partner i_far (.clk_sys(clk_sys), .rst_n(rst_n), .evt(pen), .cap_go(cap_go),
        .cap_src(cap_in), .evt_cnt(evt_cnt));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim;
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [31:0] v16);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(posedge clk_sys);
        v = rdata;
        v16 = rdata16;
    endtask : rd
    task automatic wait_ev(input int b, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pen[b] !== 1'b1 && n < 500);
        if (n >= 500) begin
            $display("mismatch at %0t: trigger wait ran out", $time);
            err_total++;
            end_sim();
        end
    endtask : wait_ev
    function automatic logic [7:0] cha(input int i, input logic [7:0] s);
        return TCCP_OFS_CH_BASE + 8'(i) * TCCP_OFS_CH_STRIDE + s;
    endfunction : cha
    function automatic logic act_out(input logic [1:0] a, input logic o);
        return (a == TCCP_ACT_SET) ? 1'b1 : (a == TCCP_ACT_CLR) ? 1'b0 :
            (a == TCCP_ACT_TGL) ? ~o : o;
    endfunction : act_out
    initial begin
        repeat (100000) @(posedge clk_sys);
        $display("mismatch at %0t: run limit reached", $time);
        err_total++;
        end_sim();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v, v16, cv, ex;
        logic [15:0] c0;
        logic [1:0] acts [4];
        logic o;
        int n, t, k, c, dl, hp, hn, hz;
        acts = '{TCCP_ACT_SET, TCCP_ACT_CLR, TCCP_ACT_TGL, TCCP_ACT_NONE};
        void'($urandom(53008));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(TCCP_OFS_TOP, v, v16);
        chk(v, TCCP_RST_TOP);
        rd(TCCP_OFS_CTRL, v, v16);
        chk(v, 32'h00000000);
        wr(8'h1c, 32'h5a5a5a5a);
        rd(8'h1c, v, v16);
        chk(v, 32'h00000000);
        wr(TCCP_OFS_TOP, 32'h1234abcd);
        rd(TCCP_OFS_TOP, v, v16);
        chk(v, 32'h1234abcd);
        chk(v16, 32'h1234abcd & TCCP_MASK16);
        t = $urandom_range(6, 2);
        wr(TCCP_OFS_TOP, 32'(t));
        wr(TCCP_OFS_CNT, 32'h00000000);
        wr(TCCP_OFS_IEN, 32'h00000001);
        wr(TCCP_OFS_CTRL, 32'h00000001);
        wait_ev(0, n);
        wait_ev(0, n);
        chk(32'(n), 32'(t + 1));
        wr(TCCP_OFS_CTRL, 32'h00000000);
        chk({31'h0, irq}, 32'h00000001);
        rd(TCCP_OFS_STS, v, v16);
        chk(v & 32'h00000001, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
        wr(TCCP_OFS_IEN, 32'h00000000);
        wr(TCCP_OFS_TOP, 32'h00000002);
        wr(TCCP_OFS_CNT, 32'h00000000);
        c0 = evt_cnt[0];
        wr(TCCP_OFS_CTRL, 32'h00000001);
        wait_ev(0, n);
        hz = 0;
        repeat (9) begin
            rd(TCCP_OFS_STS, v, v16);
            hz += int'(v[0]);
        end
        wr(TCCP_OFS_CTRL, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        rd(TCCP_OFS_STS, v, v16);
        hz += int'(v[0]);
        chk(32'(evt_cnt[0] - c0), 32'(hz));
        wr(TCCP_OFS_TOP, 32'hffffffff);
        wr(TCCP_OFS_CNT, 32'h00000000);
        wr(TCCP_OFS_CTRL, 32'h00000003);
        k = $urandom_range(20, 3);
        for (int i = 0; i < k; i++) begin
            cnt_evt_in <= 1'b1;
            @(posedge clk_sys);
            cnt_evt_in <= 1'b0;
            repeat ($urandom_range(3, 1)) @(posedge clk_sys);
        end
        rd(TCCP_OFS_CNT, v, v16);
        chk(v, 32'(k));
        wr(TCCP_OFS_CTRL, 32'h00000000);
        ex = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            c0 = evt_cnt[1];
            cv = $urandom();
            wr(TCCP_OFS_CNT, cv);
            wr(cha(0, TCCP_OFS_CH_CFG), 32'(TCCP_MODE_CAP) | 32'(i << TCCP_CFG_EDGE));
            cap_go <= 3'h1;
            @(posedge clk_sys);
            cap_go <= 3'h0;
            repeat (4) @(posedge clk_sys);
            if (i != 0) begin
                ex = cv;
            end
            rd(cha(0, TCCP_OFS_CH_CCV), v, v16);
            chk(v, ex);
            chk(32'(evt_cnt[1] - c0), 32'(i != 0) + 32'(i == 3));
        end
        wr(cha(0, TCCP_OFS_CH_CFG), 32'h00000000);
        cv = $urandom_range(32'h00ffffff, 32'h00000100);
        wr(cha(1, TCCP_OFS_CH_CCV), cv);
        wr(TCCP_OFS_CTRL, 32'h00000001);
        o = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(cha(1, TCCP_OFS_CH_CFG), 32'(TCCP_MODE_CMP) | 32'(acts[i]) << TCCP_CFG_ACT);
            wr(TCCP_OFS_CNT, cv - 32'h6);
            wait_ev(2, n);
            repeat (3) @(posedge clk_sys);
            o = act_out(acts[i], o);
            chk({30'h0, cc_out_p[1], cc_out_n[1]}, {30'h0, o, ~o});
        end
        wr(cha(1, TCCP_OFS_CH_CFG), 32'h00000000);
        wr(TCCP_OFS_CTRL, 32'h00000000);
        dl = $urandom_range(2, 0);
        wr(TCCP_OFS_DT, 32'h00000100 | 32'(dl));
        rd(TCCP_OFS_DT, v, v16);
        chk(v, 32'h00000100 | 32'(dl));
        chk(v16, 32'(dl));
        wr(TCCP_OFS_TOP, 32'h00000009);
        wr(TCCP_OFS_CNT, 32'h00000000);
        wr(cha(2, TCCP_OFS_CH_CFG), 32'(TCCP_MODE_PWM));
        for (int i = 0; i < 2; i++) begin
            c = $urandom_range(6, 4);
            wr(cha(2, TCCP_OFS_CH_CCV), 32'(c));
            wr(TCCP_OFS_CTRL, 32'h00000001);
            wait_ev(0, n);
            wait_ev(0, n);
            hp = 0;
            hn = 0;
            hz = 0;
            repeat (10) begin
                @(posedge clk_sys);
                hp += int'(cc_out_p[2]);
                hn += int'(cc_out_n[2]);
                hz += int'(!(cc_out_p[2] || cc_out_n[2]));
                chk({31'h0, cc_out_p[2] & cc_out_n[2]}, 32'h00000000);
            end
            chk(32'(hp), 32'(c - dl - 1));
            chk(32'(hn), 32'(10 - c - dl - 1));
            chk(32'(hz), 32'(2 * dl + 2));
        end
        end_sim();
    end
endmodule : tccp_timer_tb
`default_nettype wire
